// [hw/sms_defs.svh]
// Purpose: constants for the supply monitor and status glue block
// Assumes: included by bare name; definitions only
// Notes: timing counts derive from the 20 MHz system clock
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH
`define SMS_CLK_HZ 20000000
`define SMS_FRAMER_CLK_HZ 3686000
`define SMS_NUM_CH 2
`define SMS_ADDR_W 2
`define SMS_RST_INVERT 1'h0
`define SMS_RST_FWD_EN 1'h0
`define SMS_RST_SUPPLY_EN 1'h0
`define SMS_RST_WARN_IE 1'h0
`endif

// [hw/sms_pkg.sv]
// Purpose: shared types of the supply monitor block
// Assumes: nothing
// Notes: supply conditions travel as one packed struct
package sms_pkg;
    // live supply comparator levels, 1 means condition present
    typedef struct packed {
        logic field_warn;
        logic field_uv;
        logic rail_uv;
        logic logic_uv;
    } sms_supply_t;
    // live and latched status flags
    typedef struct packed {
        logic field_supply_warn;
        logic field_supply_warn_latched;
        logic field_supply_undervolt;
        logic field_supply_undervolt_latched;
    } sms_status_t;
    // power-up sequencing states
    typedef enum logic [1:0] {
        SMS_OFF = 2'b00,
        SMS_LOGIC_ONLY = 2'b01,
        SMS_RUN = 2'b10
    } sms_state_t;
endpackage : sms_pkg

// [hw/sms_supply_monitor.sv]
// Purpose: supply supervision, status flags and pin glue of a dual channel transceiver
// Assumes: supply comparators and pins are asynchronous and are synchronised here
// Notes: framer side logic runs on the framer clock input domain
`include "sms_defs.svh"
module sms_supply_monitor
    import sms_pkg::*;
#(
    parameter int NUM_CH = `SMS_NUM_CH,
    parameter int ADDR_W = `SMS_ADDR_W
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic framer_clk_i,
    input wire sms_supply_t supply_i,
    input wire logic [NUM_CH-1:0] sdci_line_i,
    input wire logic [NUM_CH-1:0] aux_digital_input_i,
    input wire logic [NUM_CH-1:0] receiver_invert_bit_i,
    input wire logic [NUM_CH-1:0] sensor_supply_enable_i,
    input wire logic [NUM_CH-1:0] driver_enable_i,
    input wire logic clock_forward_enable_i,
    input wire logic warn_int_enable_i,
    input wire logic chip_addr_bit0_i,
    input wire logic chip_addr_bit1_i,
    input wire logic [ADDR_W-1:0] target_addr_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_sdo_data_i,
    input wire logic status_read_i,
    output logic [NUM_CH-1:0] line_receive_out_o,
    output logic [NUM_CH-1:0] aux_input_logic_out_o,
    output logic [NUM_CH-1:0] line_driver_oe_n_o,
    output logic [NUM_CH-1:0] sensor_supply_on_o,
    output logic [NUM_CH-1:0] pull_current_on_o,
    output logic indicator_oe_n_o,
    output logic framer_clock_out_o,
    output logic framer_clock_out_oe_n_o,
    output sms_status_t status_o,
    output logic status_interrupt_o,
    output logic irq_n_o,
    output logic spi_selected_o,
    output logic spi_cycle_start_o,
    output logic spi_cycle_end_o,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_n_o,
    output logic spi_sample_edge_o
);
    // elaboration check on channel count and address width
    if (NUM_CH < 1 || ADDR_W != 2) begin : g_bad_param
        $error("sms_supply_monitor: unsupported parameters");
    end

    // ---- synchronisers for asynchronous pins and comparators
    localparam int SYNC_W = 4 + 3 * NUM_CH + 2 + 3;
    logic [SYNC_W-1:0] raw_async; // bundle of asynchronous levels
    logic [SYNC_W-1:0] synced; // synchronised bundle
    assign raw_async = {supply_i, sdci_line_i, aux_digital_input_i, sensor_supply_enable_i,
                        chip_addr_bit1_i, chip_addr_bit0_i, spi_cs_n_i, spi_sclk_i, spi_sdo_data_i};

    sms_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i(raw_async),
        .sync_o(synced)
    );

    sms_supply_t sup_s; // synchronised supply levels
    logic [NUM_CH-1:0] line_s; // synchronised line levels
    logic [NUM_CH-1:0] aux_s; // synchronised aux inputs
    logic [NUM_CH-1:0] ss_en_s; // synchronised sensor enable bits
    logic [1:0] addr_s; // synchronised strap pins
    logic cs_n_s; // synchronised chip select
    logic sclk_s; // synchronised serial clock
    logic sdo_data_s; // synchronised read data bit
    assign {sup_s, line_s, aux_s, ss_en_s, addr_s, cs_n_s, sclk_s, sdo_data_s} = synced;

    // ---- power sequencing state
    sms_state_t state_reg; // current supply state
    sms_state_t state_next; // next supply state
    logic all_good; // every supply above threshold
    logic soft_rst; // register reset while rail is low
    assign all_good = !sup_s.rail_uv && !sup_s.logic_uv && !sup_s.field_uv;
    assign soft_rst = sup_s.rail_uv;

    // next state from supply levels
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SMS_OFF: begin
                if (!sup_s.rail_uv && !sup_s.logic_uv) begin
                    state_next = SMS_LOGIC_ONLY;
                end
            end
            SMS_LOGIC_ONLY: begin
                if (sup_s.rail_uv || sup_s.logic_uv) begin
                    state_next = SMS_OFF;
                end else if (all_good) begin
                    state_next = SMS_RUN;
                end
            end
            SMS_RUN: begin
                if (sup_s.rail_uv || sup_s.logic_uv) begin
                    state_next = SMS_OFF;
                end else if (sup_s.field_uv) begin
                    state_next = SMS_LOGIC_ONLY;
                end
            end
            default: begin
                state_next = SMS_OFF;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= SMS_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    logic run; // field drivers allowed
    logic logic_up; // rail and logic supply good
    assign run = (state_reg == SMS_RUN);
    assign logic_up = (state_reg != SMS_OFF);

    // ---- strap capture after reset release
    logic [1:0] chip_addr_reg; // captured device address
    logic strap_done_reg; // strap taken
    logic [1:0] settle_reg; // synchroniser flush after reset
    // capture straps once, again after rail recovery
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chip_addr_reg <= 2'h0;
            strap_done_reg <= 1'h0;
        end else if (soft_rst) begin
            strap_done_reg <= 1'h0;
        end else if (!strap_done_reg && settle_reg[1]) begin
            // straps read only once the synchroniser holds real pin levels
            chip_addr_reg <= addr_s;
            strap_done_reg <= 1'h1;
        end
    end

    // ---- chip select framing
    logic cs_n_d_reg; // delayed chip select
    logic sclk_d_reg; // delayed serial clock
    logic addr_hit; // host targets this device
    assign addr_hit = strap_done_reg && (target_addr_i == chip_addr_reg);
    // edge history of select and serial clock
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            settle_reg <= 2'h0;
            cs_n_d_reg <= 1'h1;
            sclk_d_reg <= 1'h0;
        end else begin
            settle_reg <= {settle_reg[0], 1'h1}; // full after two edges
            cs_n_d_reg <= cs_n_s || !settle_reg[1]; // idle until settled, no false edge
            sclk_d_reg <= sclk_s && settle_reg[1];
        end
    end

    // cycle markers and selection, inactive without logic supply
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            spi_cycle_start_o <= 1'h0;
            spi_cycle_end_o <= 1'h0;
            spi_selected_o <= 1'h0;
            spi_sample_edge_o <= 1'h0;
        end else if (!logic_up || !settle_reg[1]) begin
            spi_cycle_start_o <= 1'h0;
            spi_cycle_end_o <= 1'h0;
            spi_selected_o <= 1'h0;
            spi_sample_edge_o <= 1'h0;
        end else begin
            spi_cycle_start_o <= cs_n_d_reg && !cs_n_s;
            spi_cycle_end_o <= !cs_n_d_reg && cs_n_s;
            spi_selected_o <= !cs_n_s && addr_hit;
            // every rising edge samples, clock idles low
            spi_sample_edge_o <= !cs_n_s && addr_hit && !sclk_d_reg && sclk_s;
        end
    end

    // serial data out, floats whenever select high
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            spi_sdo_o <= 1'h0;
            spi_sdo_oe_n_o <= 1'h1;
        end else if (cs_n_s || !logic_up || !addr_hit) begin
            spi_sdo_o <= 1'h0;
            spi_sdo_oe_n_o <= 1'h1;
        end else begin
            spi_sdo_o <= sdo_data_s;
            spi_sdo_oe_n_o <= 1'h0;
        end
    end

    // ---- status flags
    sms_status_t status_reg; // status flags
    // live flags follow supply, latched flags hold until read, set wins
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_reg <= '0;
        end else if (soft_rst) begin
            status_reg <= '0;
        end else begin
            status_reg.field_supply_warn <= sup_s.field_warn;
            status_reg.field_supply_undervolt <= sup_s.field_uv;
            if (sup_s.field_warn) begin
                status_reg.field_supply_warn_latched <= 1'h1;
            end else if (status_read_i) begin
                status_reg.field_supply_warn_latched <= 1'h0;
            end
            if (sup_s.field_uv) begin
                status_reg.field_supply_undervolt_latched <= 1'h1;
            end else if (status_read_i) begin
                status_reg.field_supply_undervolt_latched <= 1'h0;
            end
        end
    end

    logic int_cond; // interrupt condition from latched flags
    assign int_cond = (status_reg.field_supply_warn_latched && warn_int_enable_i)
                      || status_reg.field_supply_undervolt_latched;

    // status and interrupt outputs
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_o <= '0;
            status_interrupt_o <= 1'h0;
            irq_n_o <= 1'h1;
        end else begin
            status_o <= status_reg;
            status_interrupt_o <= int_cond;
            irq_n_o <= !(int_cond && logic_up);
        end
    end

    // ---- per channel pin glue
    logic [NUM_CH-1:0] inv_reg; // invert bits, reset on rail loss
    // invert bits cleared while rail is low
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            inv_reg <= '0;
        end else if (soft_rst) begin
            inv_reg <= '0;
        end else begin
            inv_reg <= receiver_invert_bit_i;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            // receiver, aux, driver, sensor supply and pulls of one channel
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    line_receive_out_o[ch] <= 1'h0;
                    aux_input_logic_out_o[ch] <= 1'h0;
                    line_driver_oe_n_o[ch] <= 1'h1;
                    sensor_supply_on_o[ch] <= `SMS_RST_SUPPLY_EN;
                    pull_current_on_o[ch] <= 1'h0;
                end else if (!logic_up) begin
                    line_receive_out_o[ch] <= 1'h0;
                    aux_input_logic_out_o[ch] <= 1'h0;
                    line_driver_oe_n_o[ch] <= 1'h1;
                    sensor_supply_on_o[ch] <= 1'h0;
                    pull_current_on_o[ch] <= 1'h0;
                end else begin
                    line_receive_out_o[ch] <= inv_reg[ch] ? line_s[ch] : !line_s[ch];
                    aux_input_logic_out_o[ch] <= !aux_s[ch];
                    line_driver_oe_n_o[ch] <= !(run && driver_enable_i[ch]);
                    sensor_supply_on_o[ch] <= ss_en_s[ch];
                    pull_current_on_o[ch] <= 1'h1;
                end
            end
        end
    endgenerate

    // indicator outputs float unless rail and logic good
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            indicator_oe_n_o <= 1'h1;
        end else begin
            indicator_oe_n_o <= !logic_up;
        end
    end
    // ---- framer clock domain
    logic fwd_en_reg; // forward enable in system domain
    // forward enable reset with rail
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fwd_en_reg <= `SMS_RST_FWD_EN;
        end else if (soft_rst) begin
            fwd_en_reg <= `SMS_RST_FWD_EN;
        end else begin
            fwd_en_reg <= clock_forward_enable_i;
        end
    end
    logic fwd_en_f; // forward enable in framer domain
    sms_sync #(.WIDTH(1)) u_fwd_sync (
        .clk_i(framer_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(fwd_en_reg),
        .sync_o(fwd_en_f)
    );
    logic fwd_gate_reg; // gate, changes only on falling framer edge
    // glitch free gate and pin enable, updated while clock low
    always_ff @(negedge framer_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fwd_gate_reg <= 1'h0;
            framer_clock_out_oe_n_o <= 1'h1;
        end else begin
            fwd_gate_reg <= fwd_en_f;
            framer_clock_out_oe_n_o <= !fwd_en_f;
        end
    end
    // forwarded clock, gated low so no runt pulse leaves the pin
    assign framer_clock_out_o = fwd_gate_reg & framer_clk_i;
endmodule : sms_supply_monitor

// [hw/sms_sync.sv]
// Purpose: two flip-flop level synchroniser, one per bit
// Assumes: destination clock free running
// Notes: first stage feeds only the second
module sms_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    // elaboration check on width
    if (WIDTH < 1) begin : g_bad_width
        $error("sms_sync: width below one");
    end
    logic [WIDTH-1:0] meta_reg; // first stage, metastable
    // capture stage then stable stage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= '0;
            sync_o <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule : sms_sync

// [test/sms_chk_monitor.sv]
// Purpose: port level checks of the supply monitor
// Assumes: bound into sms_supply_monitor, ports matched by name
// Notes: pin paths take three to four clk_i edges
module sms_chk
    import sms_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire sms_supply_t supply_i,
    input wire logic [NUM_CH-1:0] sdci_line_i,
    input wire logic [NUM_CH-1:0] aux_digital_input_i,
    input wire logic [NUM_CH-1:0] receiver_invert_bit_i,
    input wire logic [NUM_CH-1:0] sensor_supply_enable_i,
    input wire logic warn_int_enable_i,
    input wire logic spi_cs_n_i,
    input wire logic status_read_i,
    input wire logic [NUM_CH-1:0] line_receive_out_o,
    input wire logic [NUM_CH-1:0] aux_input_logic_out_o,
    input wire logic [NUM_CH-1:0] line_driver_oe_n_o,
    input wire logic [NUM_CH-1:0] sensor_supply_on_o,
    input wire sms_status_t status_o,
    input wire logic irq_n_o,
    input wire logic spi_cycle_start_o,
    input wire logic spi_sdo_oe_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // pins held still with all supplies good
    sequence s_quiet;
        (supply_i == '0 && $stable(sdci_line_i) && $stable(aux_digital_input_i)
            && $stable(receiver_invert_bit_i))[*8];
    endsequence
    // warning appears with rail and logic supply good
    sequence s_warn_rise;
        $rose(supply_i.field_warn) && !supply_i.rail_uv && !supply_i.logic_uv;
    endsequence
    property p_rx; s_quiet |-> line_receive_out_o == (~sdci_line_i ^ receiver_invert_bit_i); endproperty
    a_rx: assert property (p_rx) else $error("receive output level wrong");
    property p_aux; s_quiet |-> aux_input_logic_out_o == ~aux_digital_input_i; endproperty
    a_aux: assert property (p_aux) else $error("aux output level wrong");
    property p_drv_off;
        (supply_i.field_uv || supply_i.rail_uv || supply_i.logic_uv)[*5] |-> line_driver_oe_n_o == '1;
    endproperty
    a_drv_off: assert property (p_drv_off) else $error("driver on in lockout");
    property p_warn; s_warn_rise |-> ##[2:6] status_o.field_supply_warn_latched; endproperty
    a_warn: assert property (p_warn) else $error("warning not latched");
    property p_masked; (!warn_int_enable_i && !status_o.field_supply_undervolt_latched)[*4] |-> irq_n_o; endproperty
    a_masked: assert property (p_masked) else $error("masked warning raised irq");
    property p_uv_irq;
        (status_o.field_supply_undervolt_latched && !supply_i.logic_uv && !supply_i.rail_uv)[*5] |-> !irq_n_o;
    endproperty
    a_uv_irq: assert property (p_uv_irq) else $error("undervoltage without irq");
    property p_clear;
        (!supply_i.field_warn && !supply_i.rail_uv)[*4] ##0 status_read_i |-> ##2 !status_o.field_supply_warn_latched;
    endproperty
    a_clear: assert property (p_clear) else $error("read did not clear latch");
    property p_sdo; spi_cs_n_i[*5] |-> spi_sdo_oe_n_o; endproperty
    a_sdo: assert property (p_sdo) else $error("data out driven while deselected");
    property p_start; $fell(spi_cs_n_i) && supply_i == '0 |-> ##[2:6] spi_cycle_start_o; endproperty
    a_start: assert property (p_start) else $error("no cycle start");
    property p_sens; (sensor_supply_enable_i == '0)[*5] |-> sensor_supply_on_o == '0; endproperty
    a_sens: assert property (p_sens) else $error("sensor supply on unasked");
endmodule : sms_chk
bind sms_supply_monitor sms_chk #(.NUM_CH(NUM_CH)) u_chk (.*);

// [test/sms_host_model.sv]
// Purpose: behavioural host running one mode zero spi frame per request
// Assumes: go_i pulsed one clk_i cycle while idle
// Notes: data line flips between frames so no stale bit lingers
module sms_host_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [7:0] byte_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle bus, clock low
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        busy_o = 1'b0;
    end
    // select low, eight clocks, select high
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            cs_n_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            for (int i = 7; i >= 0; i--) begin
                mosi_o <= byte_i[i];
                repeat (2) @(posedge clk_i);
                sclk_o <= 1'b1;
                repeat (2) @(posedge clk_i);
                sclk_o <= 1'b0;
            end
            repeat (2) @(posedge clk_i);
            cs_n_o <= 1'b1;
            mosi_o <= ~mosi_o;
            busy_o <= 1'b0;
        end
    end
endmodule : sms_host_model

// [test/tb_top.sv]
// Purpose: self checking bench of the supply monitor
// Assumes: strap fixed at two from time zero
// Notes: framer clock runs at 15 ns, offset from clk_i
module tb_top
    import sms_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0, framer_clk_i = 1'b0, reset_n_i = 1'b0;
    sms_supply_t supply_i = '0;
    logic [1:0] sdci_line_i = '0, aux_digital_input_i = '0, receiver_invert_bit_i = '0;
    logic [1:0] sensor_supply_enable_i = '0, driver_enable_i = '0, target_addr_i = '0;
    logic clock_forward_enable_i = 1'b0, warn_int_enable_i = 1'b0, status_read_i = 1'b0, host_go = 1'b0;
    logic chip_addr_bit0_i = 1'b0, chip_addr_bit1_i = 1'b1; // strap value two
    logic spi_cs_n_i, spi_sclk_i, spi_sdo_data_i, host_busy, sel_seen, sdo_seen;
    logic [1:0] line_receive_out_o, aux_input_logic_out_o, line_driver_oe_n_o, sensor_supply_on_o, pull_current_on_o;
    logic indicator_oe_n_o, framer_clock_out_o, framer_clock_out_oe_n_o, status_interrupt_o, irq_n_o;
    logic spi_selected_o, spi_cycle_start_o, spi_cycle_end_o, spi_sdo_o, spi_sdo_oe_n_o, spi_sample_edge_o;
    sms_status_t status_o;
    int err_total = 0, tests_run = 0, edge_cnt, start_cnt, end_cnt, fwd_cnt;
    sms_supply_monitor DUT (.*);
    sms_host_model u_host (.clk_i(clk_i), .go_i(host_go), .byte_i(8'hA5), .cs_n_o(spi_cs_n_i),
        .sclk_o(spi_sclk_i), .mosi_o(spi_sdo_data_i), .busy_o(host_busy));
    // clocks
    always #25 clk_i = ~clk_i;
    initial begin
        #3.1;
        forever #7.5 framer_clk_i = ~framer_clk_i;
    end
    // event counters
    always @(posedge clk_i) begin
        if (spi_sample_edge_o === 1'b1) edge_cnt++;
        if (spi_cycle_start_o === 1'b1) start_cnt++;
        if (spi_selected_o === 1'b1) sel_seen = 1'b1;
        if (spi_cycle_end_o === 1'b1) end_cnt++;
        if (spi_sdo_oe_n_o === 1'b0 && spi_sdo_o === 1'b1) sdo_seen = 1'b1;
    end
    always @(posedge framer_clock_out_o) fwd_cnt++;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic read_status;
        @(posedge clk_i) status_read_i <= 1'b1;
        @(posedge clk_i) status_read_i <= 1'b0;
        cyc(3);
    endtask : read_status
    task automatic frame(input logic [1:0] a);
        @(posedge clk_i) target_addr_i <= a;
        host_go <= 1'b1;
        edge_cnt = 0;
        start_cnt = 0;
        end_cnt = 0;
        sel_seen = 1'b0;
        sdo_seen = 1'b0;
        @(posedge clk_i) host_go <= 1'b0;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_i);
            if (host_busy === 1'b0) break;
        end
        cyc(6);
    endtask : frame
    task automatic t_pins;
        for (int k = 0; k < 16; k++) begin
            @(posedge clk_i) sdci_line_i <= k[1:0];
            receiver_invert_bit_i <= k[3:2];
            aux_digital_input_i <= ~k[1:0];
            cyc(10);
            chk(line_receive_out_o === (~k[1:0] ^ k[3:2]), "receive level");
            chk(aux_input_logic_out_o === k[1:0], "aux level");
        end
    endtask : t_pins
    task automatic t_spi;
        for (int a = 0; a < 4; a++) begin
            frame(a[1:0]);
            chk(sel_seen === (a == 2), "address select");
            chk(start_cnt === 1, "cycle start");
            chk(edge_cnt === ((a == 2) ? 8 : 0), "sample edges");
            chk(end_cnt === 1, "cycle end");
            chk(sdo_seen === (a == 2), "data out driven only when addressed");
            chk(spi_sdo_oe_n_o === 1'b1, "data out floats");
        end
    endtask : t_spi
    task automatic t_sens;
        cyc(6);
        chk(sensor_supply_on_o === 2'h0, "sensor off");
        @(posedge clk_i) sensor_supply_enable_i <= 2'h1;
        cyc(6);
        chk(sensor_supply_on_o === 2'h1, "sensor on");
    endtask : t_sens
    task automatic t_warn;
        @(posedge clk_i) supply_i.field_warn <= 1'b1;
        cyc(8);
        chk(status_o.field_supply_warn === 1'b1 && status_o.field_supply_warn_latched === 1'b1, "warn");
        chk(irq_n_o === 1'b1, "masked irq");
        @(posedge clk_i) warn_int_enable_i <= 1'b1;
        cyc(4);
        chk(irq_n_o === 1'b0 && status_interrupt_o === 1'b1, "warn irq");
        @(posedge clk_i) supply_i.field_warn <= 1'b0;
        cyc(6);
        chk(status_o.field_supply_warn === 1'b0 && status_o.field_supply_warn_latched === 1'b1, "held");
        read_status();
        chk(status_o.field_supply_warn_latched === 1'b0 && irq_n_o === 1'b1, "cleared");
        @(posedge clk_i) warn_int_enable_i <= 1'b0;
    endtask : t_warn
    task automatic t_uv;
        @(posedge clk_i) driver_enable_i <= 2'h3;
        cyc(8);
        chk(line_driver_oe_n_o === 2'h0, "drivers on");
        @(posedge clk_i) supply_i.field_uv <= 1'b1;
        cyc(8);
        chk(status_o.field_supply_undervolt === 1'b1 && status_o.field_supply_undervolt_latched === 1'b1, "uv");
        chk(irq_n_o === 1'b0, "uv irq");
        chk(line_driver_oe_n_o === 2'h3, "drivers off");
        frame(2'h2);
        chk(start_cnt === 1, "spi alive");
        @(posedge clk_i) supply_i.field_uv <= 1'b0;
        cyc(6);
        read_status();
        chk(status_o.field_supply_undervolt_latched === 1'b0 && irq_n_o === 1'b1, "uv cleared");
    endtask : t_uv
    task automatic t_logic;
        @(posedge clk_i) supply_i.logic_uv <= 1'b1;
        cyc(8);
        chk(line_driver_oe_n_o === 2'h3, "drivers float");
        chk(line_receive_out_o === 2'h0 && aux_input_logic_out_o === 2'h0 && irq_n_o === 1'b1, "io low");
        @(posedge clk_i) supply_i.logic_uv <= 1'b0;
        cyc(8);
    endtask : t_logic
    task automatic t_rail;
        @(posedge clk_i) supply_i.field_warn <= 1'b1;
        cyc(8);
        @(posedge clk_i) supply_i.rail_uv <= 1'b1;
        cyc(8);
        chk(sensor_supply_on_o === 2'h0 && pull_current_on_o === 2'h0 && indicator_oe_n_o === 1'b1, "rail");
        chk(line_driver_oe_n_o === 2'h3 && status_o.field_supply_warn_latched === 1'b0, "rail reset");
        @(posedge clk_i) supply_i <= '0;
        cyc(10);
        chk(status_o.field_supply_warn_latched === 1'b0, "defaults");
        frame(2'h2);
        chk(sel_seen === 1'b1 && start_cnt === 1, "address after restart");
    endtask : t_rail
    task automatic t_fwd;
        @(posedge clk_i) clock_forward_enable_i <= 1'b1;
        cyc(4);
        fwd_cnt = 0;
        cyc(20);
        chk(fwd_cnt >= 65 && fwd_cnt <= 68, "forwarded clock");
        chk(framer_clock_out_oe_n_o === 1'b0, "clock out driven");
        @(posedge clk_i) clock_forward_enable_i <= 1'b0;
        cyc(6);
        fwd_cnt = 0;
        cyc(10);
        chk(fwd_cnt === 0, "clock stopped");
        chk(framer_clock_out_oe_n_o === 1'b1, "clock out floats");
    endtask : t_fwd
    // main sequence
    initial begin
        cyc(2);
        reset_n_i <= 1'b1;
        cyc(12);
        t_pins();
        t_sens();
        t_spi();
        t_warn();
        t_uv();
        t_logic();
        t_rail();
        t_fwd();
        stop_test();
    end
    // hang guard
    initial begin
        #400000;
        err_total++;
        stop_test();
    end
endmodule : tb_top
